// >>> design/hpsr_defines.svh
`ifndef HPSR_DEFINES_SVH
`define HPSR_DEFINES_SVH

// Setup request types
`define HPSR_RT_GET_PORT     8'hA3
`define HPSR_RT_GET_HUB      8'hA0
`define HPSR_RT_HUB_FEATURE  8'h20

// Class request codes
`define HPSR_REQ_GET_STATUS  8'h00
`define HPSR_REQ_CLEAR_FEAT  8'h01
`define HPSR_REQ_SET_FEAT    8'h03

// Hub change feature selectors
`define HPSR_FS_C_LOCAL_PWR  16'h0000
`define HPSR_FS_C_OVER_CUR   16'h0001

// Data stage length of every status request
`define HPSR_STATUS_LEN      16'h0004
`define HPSR_LAST_BYTE       2'h3

// Hub change word bit positions
`define HPSR_HC_LOCAL_PWR    0
`define HPSR_HC_OVER_CUR     1

// Port status word bit positions
`define HPSR_PS_CONNECT      0
`define HPSR_PS_ENABLE       1
`define HPSR_PS_SUSPEND      2
`define HPSR_PS_OVER_CUR     3
`define HPSR_PS_RESET        4
`define HPSR_PS_POWER        8
`define HPSR_PS_LOW_SPEED    9
`define HPSR_PS_HIGH_SPEED   10

// Port change positions that shadow a port status bit
`define HPSR_PC_MASK         16'h001F

// Reset values
`define HPSR_HUB_CHANGE_RST  2'h0
`define HPSR_WORD_RST        32'h0000_0000

`endif

// >>> design/hpsr_pkg.sv
package hpsr_pkg;

	typedef enum logic [1:0]
	{
		HPSR_ST_IDLE = 2'b00,
		HPSR_ST_SEND = 2'b01
	} hpsr_state_t;

endpackage

// >>> design/hpsr_sync.sv
`timescale 1ns/100ps

// Two-flop level synchroniser with a change pulse on the settled side
module hpsr_sync
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      sync_out,
	output logic      change_pulse
);

	logic meta_r;
	logic sync_r;
	logic prev_r;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end
		else
		begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign sync_out     = sync_r;
	assign change_pulse = sync_r ^ prev_r;

endmodule

// >>> design/hpsr_top.sv
// Function
// - Hub change bit 0 sets on local power change, clears on bus reset.
// - Hub change bit 1 sets on hub over-current change only when PER_PORT_OC is 0, clears on bus reset.
// - Reserved hub change bits 2-15 and port status bits 5-7 read zero.
// - Setting hub change bits for diagnostics optional; else Request Error.
// - ClearHubFeature on a set hub change bit clears it.
// - Setting a set feature or clearing a clear one succeeds, no change.
// - Port status request is A3h GET_STATUS, wValue 0, wIndex port, four bytes.
// - Port status word sent first, port change word second.
// - Request Error for bad wValue, bad wLength or missing port.
// - Port change bits sit at the same positions as their status bits.
// - Port status bit 0 shows a device connected.
// - Port status bit 1 shows port enabled; host alone enables.
// - Bit 2 shows suspend or resume; suspended port gets no downstream traffic.
// - With per-port over-current, bit 3 shows port over-current.
// - Bit 4 set from reset request until hub ends reset signalling.
// - Bit 8 shows logical port power state.
// - Bit 9 shows speed class, only meaningful while a device is attached.
// - Bit 9 reads 1 for low-speed, 0 for full or high speed.
// - Bit 10 reads 0 for full-speed and 1 for high-speed.
`timescale 1ns/100ps
`include "hpsr_defines.svh"

module hpsr_top
	import hpsr_pkg::*;
#(
	parameter int NUM_PORTS   = 4,
	parameter bit SET_DIAG_EN = 1'b1,
	parameter bit PER_PORT_OC = 1'b1
)
(
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   bus_reset,
	input  wire logic                   setup_valid,
	input  wire logic [7:0]             setup_req_type,
	input  wire logic [7:0]             setup_request,
	input  wire logic [15:0]            setup_value,
	input  wire logic [15:0]            setup_index,
	input  wire logic [15:0]            setup_length,
	input  wire logic                   tx_ready,
	input  wire logic                   local_power_lost,
	input  wire logic                   hub_over_current,
	input  wire logic [NUM_PORTS-1:0]   port_connect,
	input  wire logic [NUM_PORTS-1:0]   port_enable,
	input  wire logic [NUM_PORTS-1:0]   port_suspend,
	input  wire logic [NUM_PORTS-1:0]   port_over_current,
	input  wire logic [NUM_PORTS-1:0]   port_reset,
	input  wire logic [NUM_PORTS-1:0]   port_power,
	input  wire logic [NUM_PORTS-1:0]   port_low_speed,
	input  wire logic [NUM_PORTS-1:0]   port_high_speed,
	input  wire logic [16*NUM_PORTS-1:0] port_change,
	output logic                        tx_valid,
	output logic [7:0]                  tx_data,
	output logic                        tx_last,
	output logic                        req_done,
	output logic                        req_error,
	output logic                        busy,
	output logic [15:0]                 hub_change_flags,
	output logic [NUM_PORTS-1:0]        port_forward_en
);

	localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

	hpsr_state_t          state_r;
	hpsr_state_t          state_nxt;
	logic [1:0]           hub_change_r;
	logic [1:0]           hub_change_nxt;
	logic [31:0]          tx_word_r;
	logic [1:0]           tx_cnt_r;
	logic                 tx_valid_r;
	logic                 req_done_r;
	logic                 req_error_r;
	logic                 tx_last_r;
	logic                 busy_r;
	logic [NUM_PORTS-1:0] fwd_en_r;

	logic                 lp_sync;
	logic                 lp_change;
	logic                 oc_sync;
	logic                 oc_change;

	wire logic [15:0]     port_stat_w [0:NUM_PORTS-1];
	wire logic [15:0]     port_chg_w  [0:NUM_PORTS-1];

	// Hub-level inputs come from pins
	hpsr_sync u_sync_lp
	(
		.ref_clk      (ref_clk),
		.rst          (rst),
		.async_in     (local_power_lost),
		.sync_out     (lp_sync),
		.change_pulse (lp_change)
	);

	hpsr_sync u_sync_oc
	(
		.ref_clk      (ref_clk),
		.rst          (rst),
		.async_in     (hub_over_current),
		.sync_out     (oc_sync),
		.change_pulse (oc_change)
	);

	// Per-port status and change words
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++)
		begin : g_port
			assign port_stat_w[p][`HPSR_PS_CONNECT]   = port_connect[p];
			assign port_stat_w[p][`HPSR_PS_ENABLE]    = port_enable[p];
			assign port_stat_w[p][`HPSR_PS_SUSPEND]   = port_suspend[p];
			assign port_stat_w[p][`HPSR_PS_OVER_CUR]  = PER_PORT_OC & port_over_current[p];
			assign port_stat_w[p][`HPSR_PS_RESET]     = port_reset[p];
			assign port_stat_w[p][7:5]                = 3'h0;
			assign port_stat_w[p][`HPSR_PS_POWER]     = port_power[p];
			assign port_stat_w[p][`HPSR_PS_LOW_SPEED] = port_connect[p] & port_low_speed[p];
			assign port_stat_w[p][`HPSR_PS_HIGH_SPEED] = port_connect[p] & ~port_low_speed[p]
				& port_high_speed[p];
			assign port_stat_w[p][15:11]              = 5'h00;
			assign port_chg_w[p] = port_change[16*p +: 16] & `HPSR_PC_MASK;
		end
	endgenerate

	// Request decode
	wire logic is_get_port  = (setup_req_type == `HPSR_RT_GET_PORT)
		&& (setup_request == `HPSR_REQ_GET_STATUS);
	wire logic is_get_hub   = (setup_req_type == `HPSR_RT_GET_HUB)
		&& (setup_request == `HPSR_REQ_GET_STATUS);
	wire logic is_clr_hub   = (setup_req_type == `HPSR_RT_HUB_FEATURE)
		&& (setup_request == `HPSR_REQ_CLEAR_FEAT);
	wire logic is_set_hub   = (setup_req_type == `HPSR_RT_HUB_FEATURE)
		&& (setup_request == `HPSR_REQ_SET_FEAT);
	wire logic fs_lp        = (setup_value == `HPSR_FS_C_LOCAL_PWR);
	wire logic fs_oc        = (setup_value == `HPSR_FS_C_OVER_CUR);
	wire logic fs_known     = fs_lp || fs_oc;
	wire logic len_ok       = (setup_length == `HPSR_STATUS_LEN);
	wire logic val_zero     = (setup_value == 16'h0000);
	wire logic idx_zero     = (setup_index == 16'h0000);
	wire logic feat_len_ok  = (setup_length == 16'h0000);

	wire logic port_ok      = !idx_zero && (setup_index <= 16'(NUM_PORTS));
	wire logic [15:0] idx_m1 = setup_index - 16'h0001;
	wire logic [PW-1:0] port_sel = port_ok ? idx_m1[PW-1:0] : '0;

	wire logic accept       = setup_valid && (state_r == HPSR_ST_IDLE);

	wire logic get_port_ok  = is_get_port && val_zero && len_ok && port_ok;
	wire logic get_hub_ok   = is_get_hub && val_zero && idx_zero && len_ok;
	wire logic clr_ok       = is_clr_hub && fs_known && idx_zero && feat_len_ok;
	wire logic set_ok       = SET_DIAG_EN && is_set_hub && fs_known && idx_zero
		&& feat_len_ok;
	wire logic req_ok       = get_port_ok || get_hub_ok || clr_ok || set_ok;

	wire logic [15:0] hub_status_w = {14'h0000, ~PER_PORT_OC & oc_sync, lp_sync};

	// status word first, change word second
	wire logic [31:0] port_word_w = {port_chg_w[port_sel], port_stat_w[port_sel]};
	wire logic [31:0] hub_word_w  = {14'h0000, hub_change_r, hub_status_w};
	wire logic [31:0] load_word_w = get_port_ok ? port_word_w : hub_word_w;
	wire logic start_send   = accept && (get_port_ok || get_hub_ok);
	wire logic byte_taken   = tx_valid_r && tx_ready;
	wire logic last_taken   = byte_taken && (tx_cnt_r == `HPSR_LAST_BYTE);

	// Hub change flags: events win over a ClearHubFeature clear in the same cycle
	always_comb
	begin
		hub_change_nxt = hub_change_r;
		if (accept && clr_ok)
		begin
			if (fs_lp)
				hub_change_nxt[`HPSR_HC_LOCAL_PWR] = 1'b0;
			if (fs_oc)
				hub_change_nxt[`HPSR_HC_OVER_CUR] = 1'b0;
		end
		if (accept && set_ok)
		begin
			if (fs_lp)
				hub_change_nxt[`HPSR_HC_LOCAL_PWR] = 1'b1;
			if (fs_oc)
				hub_change_nxt[`HPSR_HC_OVER_CUR] = 1'b1;
		end
		if (lp_change)
			hub_change_nxt[`HPSR_HC_LOCAL_PWR] = 1'b1;
		if (oc_change && !PER_PORT_OC)
			hub_change_nxt[`HPSR_HC_OVER_CUR] = 1'b1;
	end

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			HPSR_ST_IDLE:
				if (start_send)
					state_nxt = HPSR_ST_SEND;
			HPSR_ST_SEND:
				if (last_taken)
					state_nxt = HPSR_ST_IDLE;
			default:
				state_nxt = HPSR_ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst || bus_reset)
			hub_change_r <= `HPSR_HUB_CHANGE_RST;
		else
			hub_change_r <= hub_change_nxt;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst || bus_reset)
		begin
			state_r <= HPSR_ST_IDLE;
			busy_r  <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			busy_r  <= (state_nxt != HPSR_ST_IDLE);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst || bus_reset)
		begin
			tx_word_r  <= `HPSR_WORD_RST;
			tx_cnt_r   <= 2'h0;
			tx_valid_r <= 1'b0;
			tx_last_r  <= 1'b0;
		end
		else if (start_send)
		begin
			tx_word_r  <= load_word_w;
			tx_cnt_r   <= 2'h0;
			tx_valid_r <= 1'b1;
			tx_last_r  <= 1'b0;
		end
		else if (byte_taken)
		begin
			tx_word_r  <= {8'h00, tx_word_r[31:8]};
			tx_cnt_r   <= tx_cnt_r + 2'h1;
			tx_valid_r <= !last_taken;
			// Flags the fourth byte as it comes up
			tx_last_r  <= (tx_cnt_r == 2'h2);
		end
	end

	// One-cycle completion and error pulses
	always_ff @(posedge ref_clk)
	begin
		if (rst || bus_reset)
		begin
			req_done_r  <= 1'b0;
			req_error_r <= 1'b0;
		end
		else
		begin
			req_done_r  <= (accept && (clr_ok || set_ok)) || last_taken;
			req_error_r <= accept && !req_ok;
		end
	end

	// no downstream traffic to suspended port
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			fwd_en_r <= '0;
		else
			fwd_en_r <= port_enable & ~port_suspend;
	end

	assign tx_valid         = tx_valid_r;
	assign tx_data          = tx_word_r[7:0];
	assign tx_last          = tx_last_r;
	assign req_done         = req_done_r;
	assign req_error        = req_error_r;
	assign busy             = busy_r;
	assign hub_change_flags = {14'h0000, hub_change_r};
	assign port_forward_en  = fwd_en_r;

endmodule

// >>> tb/hpsr_sva.sv
`timescale 1ns/100ps
module hpsr_sva
#(
	parameter int NUM_PORTS = 4
)
(
	input wire logic                 ref_clk,
	input wire logic                 rst,
	input wire logic                 bus_reset,
	input wire logic                 setup_valid,
	input wire logic [7:0]           setup_req_type,
	input wire logic [7:0]           setup_request,
	input wire logic [15:0]          setup_value,
	input wire logic [15:0]          setup_index,
	input wire logic [15:0]          setup_length,
	input wire logic                 tx_ready,
	input wire logic                 local_power_lost,
	input wire logic [NUM_PORTS-1:0] port_enable,
	input wire logic [NUM_PORTS-1:0] port_suspend,
	input wire logic                 tx_valid,
	input wire logic [7:0]           tx_data,
	input wire logic                 tx_last,
	input wire logic                 req_done,
	input wire logic                 req_error,
	input wire logic                 busy,
	input wire logic [15:0]          hub_change_flags,
	input wire logic [NUM_PORTS-1:0] port_forward_en
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	wire logic take = setup_valid && !busy && !bus_reset;
	wire logic feat = take && setup_req_type == 8'h20 && setup_value[15:1] == 15'h0000
		&& setup_index == 16'h0000 && setup_length == 16'h0000;
	wire logic gps = take && setup_req_type == 8'hA3 && setup_request == 8'h00;
	wire logic gok = setup_value == 16'h0000 && setup_length == 16'h0004
		&& setup_index != 16'h0000 && setup_index <= NUM_PORTS;
	property p_resv; hub_change_flags[15:2] == 14'h0000; endproperty
	a_resv: assert property (p_resv) else $error("reserved change bits set");
	property p_set; feat && setup_request == 8'h03 && !setup_value[0]
		|=> req_done && hub_change_flags[0]; endproperty
	a_set: assert property (p_set) else $error("diagnostic set failed");
	property p_clr; feat && setup_request == 8'h01 && !setup_value[0]
		&& $stable(local_power_lost) && $past(local_power_lost, 5) == local_power_lost
		|=> req_done && !hub_change_flags[0]; endproperty
	a_clr: assert property (p_clr) else $error("change bit not cleared");
	property p_noop; feat && (setup_request == 8'h01 || setup_request == 8'h03)
		|=> req_done && !req_error; endproperty
	a_noop: assert property (p_noop) else $error("feature request failed");
	property p_get; gps && gok |=> tx_valid && busy && !req_error; endproperty
	a_get: assert property (p_get) else $error("status reply missing");
	property p_err; gps && !gok |=> req_error && !tx_valid; endproperty
	a_err: assert property (p_err) else $error("bad request not refused");
	property p_hold; tx_valid && !tx_ready && !bus_reset |=> tx_valid && $stable(tx_data);
		endproperty
	a_hold: assert property (p_hold) else $error("reply byte lost");
	property p_last; tx_valid && tx_ready && tx_last && !bus_reset |=> !tx_valid && req_done;
		endproperty
	a_last: assert property (p_last) else $error("reply not closed");
	property p_brst; bus_reset |=> hub_change_flags[1:0] == 2'h0 && !tx_valid; endproperty
	a_brst: assert property (p_brst) else $error("bus reset left flags");
	property p_fwd; !$past(rst)
		|-> port_forward_en == ($past(port_enable) & ~$past(port_suspend)); endproperty
	a_fwd: assert property (p_fwd) else $error("forwarding wrong");
endmodule

bind hpsr_top hpsr_sva #(.NUM_PORTS(NUM_PORTS)) hpsr_sva_inst
(
	.ref_clk, .rst, .bus_reset, .setup_valid, .setup_req_type, .setup_request, .setup_value,
	.setup_index, .setup_length, .tx_ready, .local_power_lost, .port_enable, .port_suspend,
	.tx_valid, .tx_data, .tx_last, .req_done, .req_error, .busy, .hub_change_flags,
	.port_forward_en
);

// >>> tb/hpsr_host.sv
`timescale 1ns/100ps
module hpsr_host
(
	input wire logic        ref_clk,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        req_done,
	input wire logic        req_error,
	output logic            setup_valid,
	output logic [7:0]      setup_req_type,
	output logic [7:0]      setup_request,
	output logic [15:0]     setup_value,
	output logic [15:0]     setup_index,
	output logic [15:0]     setup_length,
	output logic            tx_ready
);
	initial
	begin
		setup_valid = 1'b0;
		{setup_req_type, setup_request, setup_value, setup_index, setup_length} = '0;
		tx_ready = 1'b0;
	end
	task automatic xfer(input logic [7:0] t, input logic [7:0] r, input logic [15:0] v,
		input logic [15:0] i, input logic [15:0] l, input bit slow,
		output logic [31:0] w, output logic e);
		w = 32'h0000_0000;
		e = 1'bx;
		@(posedge ref_clk);
		setup_valid <= 1'b1;
		{setup_req_type, setup_request, setup_value, setup_index, setup_length} <= {t, r, v, i, l};
		tx_ready <= !slow;
		@(posedge ref_clk);
		setup_valid <= 1'b0;
		// Released fields show junk, not the last request
		{setup_req_type, setup_request, setup_value, setup_index, setup_length} <= ~{t, r, v, i, l};
		for (int n = 0; n < 40; n++)
		begin
			@(posedge ref_clk);
			if (tx_valid && tx_ready)
				w = {tx_data, w[31:8]};
			if (req_done || req_error)
			begin
				e = req_error;
				n = 40;
			end
			else if (slow)
				tx_ready <= !tx_ready;
		end
	endtask
endmodule

// >>> tb/hpsr_top_tb_top.sv
`timescale 1ns/100ps
module hpsr_top_tb_top;
	logic        ref_clk, rst, bus_reset, local_power_lost, hub_over_current;
	logic [3:0]  port_connect, port_enable, port_suspend, port_over_current;
	logic [3:0]  port_reset, port_power, port_low_speed, port_high_speed, port_forward_en;
	logic [63:0] port_change;
	logic        setup_valid, tx_ready, tx_valid, tx_last, req_done, req_error, busy, e;
	logic [7:0]  setup_req_type, setup_request, tx_data;
	logic [15:0] setup_value, setup_index, setup_length, hub_change_flags;
	logic [31:0] w;
	logic [15:0] bv [4] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000};
	logic [15:0] bi [4] = '{16'h0000, 16'h0005, 16'h0001, 16'h0001};
	logic [15:0] bl [4] = '{16'h0004, 16'h0004, 16'h0004, 16'h0002};
	int          n_mismatch = 0, checks_done = 0, cyc = 0;
	hpsr_top #(.NUM_PORTS(4), .SET_DIAG_EN(1'b1), .PER_PORT_OC(1'b1)) hpsr_top_inst
	(
		.ref_clk, .rst, .bus_reset, .setup_valid, .setup_req_type, .setup_request,
		.setup_value, .setup_index, .setup_length, .tx_ready, .local_power_lost,
		.hub_over_current, .port_connect, .port_enable, .port_suspend, .port_over_current,
		.port_reset, .port_power, .port_low_speed, .port_high_speed, .port_change, .tx_valid,
		.tx_data, .tx_last, .req_done, .req_error, .busy, .hub_change_flags, .port_forward_en
	);
	hpsr_host hpsr_host_inst
	(
		.ref_clk, .tx_valid, .tx_data, .req_done, .req_error, .setup_valid, .setup_req_type,
		.setup_request, .setup_value, .setup_index, .setup_length, .tx_ready
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic hub(input logic [7:0] r, input logic [15:0] v, input logic [15:0] exp);
		hpsr_host_inst.xfer(8'h20, r, v, 16'h0000, 16'h0000, 1'b0, w, e);
		chk({e, 15'h0000, hub_change_flags}, {16'h0000, exp});
	endtask
	task automatic port(input logic [15:0] i, input bit slow, input logic [31:0] exp);
		hpsr_host_inst.xfer(8'hA3, 8'h00, 16'h0000, i, 16'h0004, slow, w, e);
		chk(w, exp);
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial
	begin
		{rst, bus_reset, local_power_lost, hub_over_current} = 4'h8;
		{port_connect, port_enable, port_suspend, port_over_current} = '0;
		{port_reset, port_power, port_low_speed, port_high_speed, port_change} = '0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		{port_connect, port_enable, port_suspend, port_over_current} <= 16'h6644;
		{port_reset, port_power, port_low_speed, port_high_speed} <= 16'h46AC;
		port_change <= {16'hFFFF, 16'h0012, 16'hFFFF, 16'h0000};
		port(16'h0002, 1'b0, 32'h001F_0303);
		port(16'h0003, 1'b1, 32'h0012_051F);
		port(16'h0004, 1'b0, 32'h001F_0000);
		chk({28'h0000000, port_forward_en}, 32'h0000_0002);
		$display("test port_status done");
		for (int k = 0; k < 4; k++)
		begin
			hpsr_host_inst.xfer(8'hA3, 8'h00, bv[k], bi[k], bl[k], 1'b0, w, e);
			chk({31'h00000000, e}, 32'h0000_0001);
		end
		$display("test request_error done");
		hub(8'h03, 16'h0000, 16'h0001);
		hub(8'h03, 16'h0000, 16'h0001);
		hub(8'h01, 16'h0000, 16'h0000);
		hub(8'h01, 16'h0000, 16'h0000);
		hub(8'h03, 16'h0001, 16'h0002);
		hub(8'h03, 16'h0000, 16'h0003);
		bus_reset <= 1'b1;
		@(posedge ref_clk);
		bus_reset <= 1'b0;
		@(posedge ref_clk);
		chk({16'h0000, hub_change_flags}, 32'h0000_0000);
		local_power_lost <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk({16'h0000, hub_change_flags}, 32'h0000_0001);
		hpsr_host_inst.xfer(8'hA0, 8'h00, 16'h0000, 16'h0000, 16'h0004, 1'b0, w, e);
		chk(w, 32'h0001_0001);
		hub(8'h01, 16'h0000, 16'h0000);
		$display("test hub_change done");
		print_verdict();
	end
endmodule
